// ===== src/adcsc_pkg.sv
// package: constants and carrier types for the adc serial sampling control block
package adcsc_pkg;
  // command codes, top nibble of a frame
  localparam logic [3:0] CMD_SELECT_BASE = 4'h0;
  localparam logic [3:0] CMD_SELF_TEST_BASE = 4'hB;
  localparam logic [3:0] CMD_SW_POWERDOWN = 4'h8;
  localparam logic [3:0] CMD_READ_FIFO = 4'hE;
  localparam logic [3:0] CMD_CONFIG_WRITE = 4'hA;
  localparam logic [3:0] CMD_SWEEP_WRITE = 4'hF;
  localparam logic [3:0] CMD_NOP = 4'h9;
  // frame layout
  localparam int FRAME_BITS = 16;
  localparam int CMD_BITS = 4;
  localparam int DATA_BITS = 12;
  // edge count at which sampling starts
  localparam logic [4:0] SAMPLE_START_EDGE = 5'h04;
  // sampling lengths in serial clocks
  localparam logic [4:0] SAMPLE_SHORT_SCLKS = 5'h0C;
  localparam logic [4:0] SAMPLE_LONG_SCLKS = 5'h18;
  // configuration field positions
  localparam int CFG_LONG_SAMPLE_BIT = 0;
  localparam int CFG_SCLK_CONV_BIT = 1;
  localparam int CFG_INT_MODE_BIT = 2;
  localparam int CFG_AUTO_PD_BIT = 3;
  localparam int CFG_SWEEP_EN_BIT = 4;
  localparam logic [11:0] CFG_RESET = 12'h000;
  localparam logic [7:0] SWEEP_RESET = 8'hFF;
  // conversion length in conversion clocks
  localparam logic [4:0] CONV_CLOCKS = 5'h0E;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_STAGES = 3;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic fs_n;
    logic sin;
    logic start_n;
    logic pd_n;
  } adcsc_pins_type;

  typedef struct packed {
    logic long_sample;
    logic sclk_conv;
    logic int_mode;
    logic auto_pd;
    logic sweep_en;
  } adcsc_cfg_type;
endpackage

// ===== src/adcsc_sync.sv
// three-flop pin synchroniser with agreement of the last two stages
module adcsc_sync #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // pins
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts only once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_agree
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          pin_out[i] <= 1'b1;
        end else if (s2_q[i] == s3_q[i]) begin
          pin_out[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule // adcsc_sync

// ===== src/adcsc_top.sv
// serial front end, sampling control, conversion sequencing and result fifo
// Functional notes
// - normal sampling starts by itself after the fourth serial clock edge
// - sampling lasts 12 or 24 serial clocks by configuration
// - extended sampling: sample start pin low time sets the sampling period
// - conversion clock is the internal oscillator or the serial clock
// - chip select fall clears edge counter, enables input only if frame sync is high, drives output
// - input stops at 16 edges or chip select rise, whichever first
// - results sit in an eight-deep fifo read out serially
// - multiplexer picks an input channel or one of three self-test levels
// - software, hardware pin and automatic power-down modes
// - automatic sweep steps channels without a select per channel
// - one selected analog input is sampled at a time
// - frames go msb first: 4-bit command, config writes add 12 data bits
// - capture on rising edges with frame sync high, falling when framed
// - frame sync fall clears counter and enables input regardless of chip select
// - end of conversion low from sampling end to data ready; int mode low from data ready until next chip select or frame sync fall
module adcsc_top #(
  parameter int CHANNELS = 8,
  parameter int FIFO_DEPTH = adcsc_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic frame_sync,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe_n,
  // control pins
  input wire logic sample_start_pin,
  input wire logic hw_powerdown_n,
  input wire logic internal_conv_oscillator,
  // converter side
  input wire logic [11:0] conv_data,
  output logic [3:0] mux_select,
  output logic sampling,
  output logic converting,
  output logic powered_down,
  output logic eoc_int_n
);
  typedef enum logic [2:0] {IDLE, SAMPLE, EXT_SAMPLE, CONVERT, STORE} adcsc_state_type;

  adcsc_pkg::adcsc_pins_type raw;
  adcsc_pkg::adcsc_pins_type pin;
  adcsc_pkg::adcsc_pins_type pin_q;
  adcsc_pkg::adcsc_cfg_type cfg;
  logic osc_q;
  logic osc_s_q;
  logic osc_r_q;

  assign raw = '{sclk: sclk, cs_n: cs_n, fs_n: frame_sync, sin: serial_in,
                 start_n: sample_start_pin, pd_n: hw_powerdown_n};

  adcsc_sync #(
    .WIDTH($bits(adcsc_pkg::adcsc_pins_type))
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin_in(raw),
    .pin_out(pin)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_q <= '1;
      osc_q <= 1'b0;
      osc_s_q <= 1'b0;
      osc_r_q <= 1'b0;
    end else begin
      pin_q <= pin;
      osc_q <= internal_conv_oscillator;
      osc_s_q <= osc_q;
      osc_r_q <= osc_s_q;
    end
  end

  wire sclk_rise = pin.sclk & ~pin_q.sclk;
  wire sclk_fall = ~pin.sclk & pin_q.sclk;
  wire cs_fall = ~pin.cs_n & pin_q.cs_n;
  wire cs_rise = pin.cs_n & ~pin_q.cs_n;
  wire fs_fall = ~pin.fs_n & pin_q.fs_n;
  wire osc_rise = osc_s_q & ~osc_r_q;

  // ---- serial frame ----
  logic [4:0] edge_cnt_q;
  logic in_en_q;
  logic framed_q;
  logic [15:0] shift_q;
  logic frame_done_q;
  logic [4:0] sample_cnt_q;

  wire cap_edge = framed_q ? sclk_fall : sclk_rise;
  wire take_bit = in_en_q & cap_edge & ~cs_rise;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      edge_cnt_q <= 5'h00;
      in_en_q <= 1'b0;
      framed_q <= 1'b0;
      shift_q <= 16'h0000;
      frame_done_q <= 1'b0;
    end else begin
      frame_done_q <= 1'b0;
      if (fs_fall) begin
        edge_cnt_q <= 5'h00;
        in_en_q <= 1'b1;
        framed_q <= 1'b1;
      end else if (cs_fall) begin
        edge_cnt_q <= 5'h00;
        in_en_q <= pin.fs_n;
        framed_q <= 1'b0;
      end else if (cs_rise) begin
        in_en_q <= 1'b0;
      end else if (take_bit) begin
        shift_q <= {shift_q[14:0], pin.sin};
        edge_cnt_q <= edge_cnt_q + 5'h01;
        if (edge_cnt_q == 5'(adcsc_pkg::FRAME_BITS - 1)) begin
          in_en_q <= 1'b0;
          frame_done_q <= 1'b1;
        end
      end
    end
  end

  // ---- command decode and configuration ----
  logic [11:0] cfg_q;
  logic [7:0] sweep_mask_q;
  logic [3:0] sel_q;
  logic sw_pd_q;
  logic read_pop;

  assign cfg = '{long_sample: cfg_q[adcsc_pkg::CFG_LONG_SAMPLE_BIT],
                 sclk_conv: cfg_q[adcsc_pkg::CFG_SCLK_CONV_BIT],
                 int_mode: cfg_q[adcsc_pkg::CFG_INT_MODE_BIT],
                 auto_pd: cfg_q[adcsc_pkg::CFG_AUTO_PD_BIT],
                 sweep_en: cfg_q[adcsc_pkg::CFG_SWEEP_EN_BIT]};

  wire [3:0] cmd = shift_q[15:12];
  // command nibble is known once four bits are in
  wire cmd_ready = take_bit & (edge_cnt_q == adcsc_pkg::SAMPLE_START_EDGE - 5'h01);
  wire [3:0] cmd_now = {shift_q[2:0], pin.sin};
  wire cmd_is_select = cmd_now < 4'(CHANNELS);
  wire cmd_is_test = cmd_now >= adcsc_pkg::CMD_SELF_TEST_BASE && cmd_now < adcsc_pkg::CMD_READ_FIFO;
  wire start_conv = cmd_ready & (cmd_is_select | cmd_is_test | (cfg.sweep_en & cmd_now == adcsc_pkg::CMD_NOP));
  assign read_pop = cmd_ready & (cmd_now == adcsc_pkg::CMD_READ_FIFO);

  function automatic logic [3:0] next_sweep(input logic [3:0] cur, input logic [7:0] mask);
    logic [3:0] n;
    n = cur;
    for (int k = 1; k <= 8; k++) begin
      if (mask[3'(cur + 4'(k))] && n == cur) begin
        n = {1'b0, 3'(cur + 4'(k))};
      end
    end
    return n;
  endfunction

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_q <= adcsc_pkg::CFG_RESET;
      sweep_mask_q <= adcsc_pkg::SWEEP_RESET;
      sel_q <= 4'h0;
      sw_pd_q <= 1'b0;
    end else begin
      if (frame_done_q && cmd == adcsc_pkg::CMD_CONFIG_WRITE) begin
        cfg_q <= shift_q[11:0];
      end
      if (frame_done_q && cmd == adcsc_pkg::CMD_SWEEP_WRITE) begin
        sweep_mask_q <= shift_q[7:0];
      end
      if (cmd_ready && cmd_now == adcsc_pkg::CMD_SW_POWERDOWN) begin
        sw_pd_q <= 1'b1;
      end else if (cs_fall || fs_fall) begin
        sw_pd_q <= 1'b0;
      end
      if (cmd_ready && (cmd_is_select || cmd_is_test)) begin
        sel_q <= cmd_now;
      end else if (cmd_ready && cfg.sweep_en && cmd_now == adcsc_pkg::CMD_NOP) begin
        // step as sampling starts so the input stays put while it is sampled
        sel_q <= next_sweep(sel_q, sweep_mask_q);
      end
    end
  end

  // ---- sampling and conversion sequencer ----
  adcsc_state_type state_q;
  logic [4:0] conv_cnt_q;
  wire conv_tick = cfg.sclk_conv ? sclk_rise : osc_rise;
  wire [4:0] sample_len = cfg.long_sample ? adcsc_pkg::SAMPLE_LONG_SCLKS : adcsc_pkg::SAMPLE_SHORT_SCLKS;
  logic fifo_push;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= IDLE;
      sample_cnt_q <= 5'h00;
      conv_cnt_q <= 5'h00;
    end else begin
      case (state_q)
        IDLE: begin
          if (start_conv && !powered_down) begin
            sample_cnt_q <= 5'h00;
            state_q <= pin.start_n ? SAMPLE : EXT_SAMPLE;
          end else if (!pin.start_n && pin_q.start_n && pin.cs_n && !powered_down) begin
            state_q <= EXT_SAMPLE;
          end
        end
        SAMPLE: begin
          if (cap_edge) begin
            sample_cnt_q <= sample_cnt_q + 5'h01;
            if (sample_cnt_q == sample_len - 5'h01) begin
              conv_cnt_q <= 5'h00;
              state_q <= CONVERT;
            end
          end else if (cs_rise) begin
            conv_cnt_q <= 5'h00;
            state_q <= CONVERT;
          end
        end
        EXT_SAMPLE: begin
          if (pin.start_n && pin.cs_n) begin
            conv_cnt_q <= 5'h00;
            state_q <= CONVERT;
          end
        end
        CONVERT: begin
          if (conv_tick) begin
            conv_cnt_q <= conv_cnt_q + 5'h01;
            if (conv_cnt_q == adcsc_pkg::CONV_CLOCKS - 5'h01) begin
              state_q <= STORE;
            end
          end
        end
        STORE: state_q <= IDLE;
        default: state_q <= IDLE;
      endcase
    end
  end
  assign fifo_push = state_q == STORE;

  // ---- result fifo ----
  localparam int AW = $clog2(FIFO_DEPTH);
  logic [11:0] mem_q [FIFO_DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] count_q;
  wire do_pop = read_pop && count_q != '0;
  wire do_push = fifo_push && count_q != (AW+1)'(FIFO_DEPTH);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end else begin
      if (do_push) begin
        mem_q[wr_q] <= conv_data;
        wr_q <= AW'(wr_q + 1'b1);
      end
      if (do_pop) begin
        rd_q <= AW'(rd_q + 1'b1);
      end
      // a push into a full fifo is dropped
      if (do_push && !do_pop) begin
        count_q <= count_q + 1'b1;
      end else if (do_pop && !do_push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  // ---- serial output ----
  logic [11:0] out_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      serial_out <= 1'b0;
      serial_out_oe_n <= 1'b1;
      out_q <= 12'h000;
    end else begin
      serial_out_oe_n <= pin.cs_n & ~framed_q;
      if (cs_rise) begin
        serial_out_oe_n <= 1'b1;
      end
      if ((cs_fall || fs_fall) && count_q == '0) begin
        out_q <= 12'h000;
      end else if (cs_fall || fs_fall) begin
        out_q <= mem_q[rd_q];
      end else if (sclk_fall && !pin.cs_n) begin
        out_q <= {out_q[10:0], 1'b0};
      end
      serial_out <= out_q[11];
    end
  end

  // ---- status outputs ----
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mux_select <= 4'h0;
      sampling <= 1'b0;
      converting <= 1'b0;
      powered_down <= 1'b0;
      eoc_int_n <= 1'b1;
    end else begin
      mux_select <= sel_q;
      sampling <= state_q == SAMPLE || state_q == EXT_SAMPLE;
      converting <= state_q == CONVERT;
      powered_down <= ~pin.pd_n | sw_pd_q | (cfg.auto_pd & state_q == IDLE);
      if (cfg.int_mode) begin
        if (fifo_push) begin
          eoc_int_n <= 1'b0;
        end else if (cs_fall || fs_fall) begin
          eoc_int_n <= 1'b1;
        end
      end else begin
        eoc_int_n <= state_q != CONVERT;
      end
    end
  end
endmodule // adcsc_top

// ===== sim/adcsc_checker_sva.sv
// port assertions for the sampling control block
module adcsc_checker #(
  parameter int CHANNELS = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // watched ports
  input wire logic cs_n,
  input wire logic hw_powerdown_n,
  input wire logic serial_out_oe_n,
  input wire logic [3:0] mux_select,
  input wire logic sampling,
  input wire logic converting,
  input wire logic powered_down,
  input wire logic eoc_int_n
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_cs_fall_drive: assert property ($fell(cs_n) |-> ##[1:8] !serial_out_oe_n)
    else $error("output not driven after select");
  a_cs_rise_release: assert property ($rose(cs_n) |-> ##[1:8] serial_out_oe_n)
    else $error("output not released after deselect");
  a_pin_pd_enter: assert property (!hw_powerdown_n [*8] |=> powered_down)
    else $error("pin power-down not entered");
  a_pd_quiet: assert property (powered_down |-> !sampling && !converting)
    else $error("activity while powered down");
  a_one_phase: assert property (!(sampling && converting))
    else $error("sampling and converting together");
  a_mux_range: assert property (mux_select < CHANNELS || (mux_select >= 4'hB && mux_select <= 4'hD))
    else $error("multiplexer code out of range");
  a_mux_hold: assert property (sampling && $past(sampling) |-> $stable(mux_select))
    else $error("multiplexer moved while sampling");
  a_conv_follows: assert property ($rose(converting) |-> $past(sampling))
    else $error("conversion without sampling");
  a_conv_min: assert property ($rose(converting) |=> converting [*8])
    else $error("conversion too short");
  c_sample: cover property ($rose(sampling));
  c_ready: cover property ($fell(eoc_int_n));
  c_pd: cover property ($rose(powered_down));
endmodule // adcsc_checker

bind adcsc_top adcsc_checker #(.CHANNELS(CHANNELS)) u_chk (.core_clk(core_clk), .rst(rst), .cs_n(cs_n),
  .hw_powerdown_n(hw_powerdown_n), .serial_out_oe_n(serial_out_oe_n), .mux_select(mux_select),
  .sampling(sampling), .converting(converting), .powered_down(powered_down), .eoc_int_n(eoc_int_n));

// ===== sim/adcsc_host.sv
// host serial port model sending frames to the block
module adcsc_host (
  // clock
  input wire logic core_clk,
  // serial link
  output logic sclk,
  output logic cs_n,
  output logic frame_sync,
  output logic serial_in,
  input wire logic serial_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    frame_sync = 1'b1;
    serial_in = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // sclk is low whenever cs_n or frame_sync moves; 400 ns serial clock
  task automatic xfer(input logic [15:0] word, input int pulses, input bit use_fs, output logic [15:0] rd);
    rd = 16'h0000;
    if (use_fs) frame_sync <= 1'b0;
    else cs_n <= 1'b0;
    tick(8);
    frame_sync <= 1'b1;
    for (int i = 0; i < pulses; i++) begin
      // data changes half a period before the capturing edge
      if (!use_fs) serial_in <= (i < 16) ? word[15 - i] : ~serial_in;
      tick(4);
      sclk <= 1'b1;
      if (use_fs) serial_in <= (i < 16) ? word[15 - i] : ~serial_in;
      tick(4);
      if (i < 16) rd[15 - i] = serial_out;
      sclk <= 1'b0;
    end
    tick(4);
    cs_n <= 1'b1;
    serial_in <= ~serial_in;
    tick(8);
  endtask
endmodule // adcsc_host

// ===== sim/adc_serial_sampling_control_tb_top.sv
// testbench for the sampling control block
module adc_serial_sampling_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic sclk, cs_n, frame_sync, serial_in, serial_out, serial_out_oe_n;
  logic sample_start_pin = 1'b1;
  logic hw_powerdown_n = 1'b1;
  logic [1:0] osc_cnt = 2'h0;
  logic [11:0] conv_data = 12'hA5C;
  logic [3:0] mux_select;
  logic sampling, converting, powered_down, eoc_int_n;
  logic [2:0] obs;
  logic [15:0] rd;
  logic [3:0] codes [5] = '{4'h3, 4'h0, 4'hB, 4'hC, 4'hD};
  int num_errors = 0;
  int checked = 0;
  int samp_sclks = 0;
  assign obs = {eoc_int_n, converting, sampling};
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) osc_cnt <= osc_cnt + 2'h1;
  bit fs_mode = 1'b0;
  always @(posedge sclk) if (!fs_mode && sampling === 1'b1) samp_sclks++;
  always @(negedge sclk) if (fs_mode && sampling === 1'b1) samp_sclks++;
  adcsc_host host (.core_clk(core_clk), .sclk(sclk), .cs_n(cs_n), .frame_sync(frame_sync),
    .serial_in(serial_in), .serial_out(serial_out));
  adcsc_top DUT (.core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .frame_sync(frame_sync),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
    .sample_start_pin(sample_start_pin), .hw_powerdown_n(hw_powerdown_n),
    .internal_conv_oscillator(osc_cnt[1]), .conv_data(conv_data), .mux_select(mux_select),
    .sampling(sampling), .converting(converting), .powered_down(powered_down), .eoc_int_n(eoc_int_n));
  task automatic give_verdict();
    $display("errors %0d of %0d compares", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_on(input int which, input logic val);
    for (int n = 0; n < 3000; n++) begin
      if (obs[which] === val) return;
      @(posedge core_clk);
    end
    check({15'h0000, obs[which]}, {15'h0000, val});
    give_verdict();
  endtask
  // one select frame, then sampling length and ready flag
  task automatic select(input logic [3:0] code, input int pulses, input bit use_fs, input logic [4:0] len);
    samp_sclks = 0;
    fs_mode = use_fs;
    host.xfer({code, 12'h000}, pulses, use_fs, rd);
    check(mux_select, code);
    check(samp_sclks, len);
    check(eoc_int_n, 1'b1);
    wait_on(1, 1'b0);
    check(eoc_int_n, 1'b0);
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    repeat (8) @(posedge core_clk);
    host.xfer({adcsc_pkg::CMD_CONFIG_WRITE, 12'h004}, 16, 1'b0, rd);
    foreach (codes[i]) select(codes[i], 16, 1'b0, adcsc_pkg::SAMPLE_SHORT_SCLKS);
    select(4'h5, 16, 1'b1, adcsc_pkg::SAMPLE_SHORT_SCLKS);
    host.xfer({adcsc_pkg::CMD_CONFIG_WRITE, 12'h005}, 16, 1'b0, rd);
    select(4'h6, 28, 1'b0, adcsc_pkg::SAMPLE_LONG_SCLKS);
    host.xfer({adcsc_pkg::CMD_READ_FIFO, 12'h000}, 16, 1'b0, rd);
    check(rd[15:4], conv_data);
    sample_start_pin <= 1'b0;
    repeat (40) @(posedge core_clk);
    check(sampling, 1'b1);
    check(converting, 1'b0);
    sample_start_pin <= 1'b1;
    repeat (10) @(posedge core_clk);
    check(converting, 1'b1);
    wait_on(1, 1'b0);
    hw_powerdown_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    check(powered_down, 1'b1);
    hw_powerdown_n <= 1'b1;
    host.xfer({adcsc_pkg::CMD_SW_POWERDOWN, 12'h000}, 16, 1'b0, rd);
    check(powered_down, 1'b1);
    host.xfer({adcsc_pkg::CMD_NOP, 12'h000}, 16, 1'b0, rd);
    check(powered_down, 1'b0);
    host.xfer({adcsc_pkg::CMD_CONFIG_WRITE, 12'h008}, 16, 1'b0, rd);
    check(powered_down, 1'b1);
    host.xfer({adcsc_pkg::CMD_CONFIG_WRITE, 12'h016}, 16, 1'b0, rd);
    check(powered_down, 1'b0);
    host.xfer({adcsc_pkg::CMD_SWEEP_WRITE, 12'h005}, 16, 1'b0, rd);
    host.xfer({adcsc_pkg::CMD_NOP, 12'h000}, 30, 1'b0, rd);
    check(mux_select, 4'h0);
    wait_on(1, 1'b0);
    check(eoc_int_n, 1'b0);
    host.xfer({adcsc_pkg::CMD_NOP, 12'h000}, 30, 1'b0, rd);
    check(mux_select, 4'h2);
    wait_on(1, 1'b0);
    check(eoc_int_n, 1'b0);
    give_verdict();
  end
endmodule // adc_serial_sampling_control_tb_top
